//--- include/dts_pkg.sv
package dts_pkg;
	// Register byte addresses on the Wishbone slave
	localparam logic [7:0] ADR_TRIG_CONFIG = 8'h00;
	localparam logic [7:0] ADR_TRACE_STATUS = 8'h04;
	localparam logic [7:0] ADR_DEBUG_CONTROL = 8'h08;
	// trigger_config fields
	localparam int TAG_FORCE_SELECT_BIT = 7;
	localparam int CAPTURE_BEGIN_BIT = 6;
	localparam logic [7:0] TRIG_CONFIG_WRITE_MASK = 8'hcf;
	localparam logic [7:0] TRIG_CONFIG_RESET = 8'h00;
	// trace_status fields
	localparam int MATCH_A_FLAG_BIT = 7;
	localparam int MATCH_B_FLAG_BIT = 6;
	localparam int RUN_ACTIVE_FLAG_BIT = 5;
	// debug_control_reg fields
	localparam int DEBUG_UNIT_ENABLE_BIT = 7;
	localparam int RUN_ACTIVE_CTRL_BIT = 6;
	// Trigger mode field codes
	localparam logic [3:0] MODE_A_ONLY = 4'h0;
	localparam logic [3:0] MODE_A_OR_B = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B = 4'h2;
	localparam logic [3:0] MODE_EVENT_B = 4'h3;
	localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
	localparam logic [3:0] MODE_A_AND_DATA_B = 4'h5;
	localparam logic [3:0] MODE_A_AND_NOT_DATA_B = 4'h6;
	localparam logic [3:0] MODE_INSIDE_RANGE = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE_RANGE = 4'h8;
	localparam logic [3:0] MODE_FIRST_DEAD = 4'h9;
	// Trace buffer depth in words
	localparam int TRACE_DEPTH = 8;
endpackage

//--- include/dts_cnt_if.sv
interface dts_cnt_if;
	logic clear;
	logic inc;
	logic [3:0] count;
	modport owner (input clear, input inc, output count);
	modport user (output clear, output inc, input count);
endinterface

//--- rtl/dts_valid_counter.sv
module dts_valid_counter
	import dts_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH
) (
	input wire logic sys_clk,
	input wire logic nrst,
	dts_cnt_if.owner cnt
);
	localparam logic [3:0] MAX_COUNT = 4'(DEPTH);

	// Refuse depths that the four-bit count cannot hold
	if (DEPTH < 1 || DEPTH > 15) begin : g_depth_check
		$error("dts_valid_counter: DEPTH must lie in 1..15");
	end

	logic [3:0] count_q;

	// Clears at run start, saturates when the buffer is full, never counts down
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			count_q <= 4'h0;
		end else if (cnt.clear) begin
			count_q <= 4'h0;
		end else if (cnt.inc && count_q < MAX_COUNT) begin
			count_q <= count_q + 4'h1;
		end
	end

	assign cnt.count = count_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_count_bounded: assert property (count_q <= MAX_COUNT)
		else $error("valid count above buffer depth");
	a_count_no_down: assert property (!cnt.clear |=> count_q >= $past(count_q))
		else $error("valid count decreased without run start");
endmodule

//--- rtl/dts_trigger_status.sv
// What this block does
// - trigger_config always readable; writes land only while no run is active.
// - trigger_config bits 4 and 5 read zero and ignore writes.
// - Bit 7 set: match triggers only once its opcode executes; clear: access triggers.
// - Bit 6 selects end trace (fill until trigger) or begin trace.
// - Event-only modes ignore bit 6 and always run as begin traces.
// - Modes 0-4: A only, A or B, A then B, event B, A then event B.
// - Mode 5 A and data B, mode 6 A and not data B, 9-15 none.
// - Mode 7 triggers inside A..B inclusive, mode 8 outside that range.
// - Match A flag clears at run start, sets on a later A match.
// - Match B flag clears at run start, sets on a later B match.
// - Status bit 5 mirrors run control; set by a write with the run and enable bits both one.
// - Run ends on buffer full in begin trace, on trigger in end trace.
// - Writing zero to run control or unit enable stops a run at once.
// - Valid count clears at run start, holds 0..8 valid words at end.
// - Valid count does not decrement when trace words are read.
// - trace_status is read only; writes change nothing.
// - Write sets run control and flag; run completion clears control.
// - Event-only modes store low byte only; high byte reads zero.
// - Break requests never alter qualification; timing follows begin or end.
module dts_trigger_status
	import dts_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic busAccess,
	input wire logic hitA,
	input wire logic hitB,
	input wire logic dataHitB,
	input wire logic addrGeA,
	input wire logic addrLeB,
	input wire logic opcodeExec,
	input wire logic wordStored,
	input wire logic fifoFull,
	output logic trigger,
	output logic captureEn,
	output logic eventStore,
	output logic lowByteOnly,
	output logic breakReq,
	output logic runActive,
	output logic unitEnable
);
	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_WAIT, ST_POST} dts_state_type;

	logic ack_q;
	logic [31:0] rdData_q;
	logic [7:0] trigCfg_q;
	logic enable_q;
	logic run_q;
	logic afFlag_q;
	logic bfFlag_q;
	logic seenA_q;
	logic tagPend_q;
	logic trigger_q;
	logic captureEn_q;
	logic eventStore_q;
	logic lowByte_q;
	logic breakReq_q;
	dts_state_type state_q;
	dts_state_type stateNext;
	logic reqNew;
	logic wrDo;
	logic wrTrig;
	logic wrStat;
	logic wrCtrl;
	logic runStart;
	logic runStop;
	logic runEnd;
	logic [3:0] mode;
	logic eventOnly;
	logic beginMode;
	logic tagSel;
	logic rawTrig;
	logic trig;
	logic [7:0] statusVal;
	logic [7:0] rdSel;

	dts_cnt_if cnt ();

	dts_valid_counter #(.DEPTH(TRACE_DEPTH)) uCount (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.cnt(cnt)
	);

	// Bus decode: new request, write commits on the edge that sees ack high
	assign reqNew = wb_cyc_i && wb_stb_i && !ack_q;
	assign wrDo = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
	assign wrTrig = wrDo && (wb_adr_i == ADR_TRIG_CONFIG);
	assign wrStat = wrDo && (wb_adr_i == ADR_TRACE_STATUS);
	assign wrCtrl = wrDo && (wb_adr_i == ADR_DEBUG_CONTROL);

	// Run control decode
	assign runStart = wrCtrl && wb_dat_i[DEBUG_UNIT_ENABLE_BIT]
		&& wb_dat_i[RUN_ACTIVE_CTRL_BIT] && !run_q;
	assign runStop = wrCtrl && run_q && (!wb_dat_i[DEBUG_UNIT_ENABLE_BIT]
		|| !wb_dat_i[RUN_ACTIVE_CTRL_BIT]);

	// Configuration fields
	assign mode = trigCfg_q[3:0];
	assign eventOnly = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
	assign beginMode = trigCfg_q[CAPTURE_BEGIN_BIT] || eventOnly;
	assign tagSel = trigCfg_q[TAG_FORCE_SELECT_BIT];

	// Raw comparator combination per trigger mode
	always_comb begin
		rawTrig = 1'b0;
		case (mode)
			MODE_A_ONLY: rawTrig = hitA;
			MODE_A_OR_B: rawTrig = hitA || hitB;
			MODE_A_THEN_B: rawTrig = hitB && seenA_q;
			MODE_EVENT_B: rawTrig = hitB;
			MODE_A_THEN_EVENT_B: rawTrig = hitB && seenA_q;
			MODE_A_AND_DATA_B: rawTrig = hitA && dataHitB;
			MODE_A_AND_NOT_DATA_B: rawTrig = hitA && !dataHitB;
			MODE_INSIDE_RANGE: rawTrig = addrGeA && addrLeB;
			MODE_OUTSIDE_RANGE: rawTrig = !addrGeA || !addrLeB;
			default: rawTrig = 1'b0;
		endcase
		rawTrig = rawTrig && busAccess && run_q;
	end

	// Tag waits for execution of the matched opcode, force takes the access
	assign trig = tagSel ? (tagPend_q && opcodeExec && run_q) : rawTrig;

	// Natural end of a run
	assign runEnd = run_q && ((beginMode && state_q == ST_POST && fifoFull)
		|| (!beginMode && state_q == ST_PRE && trig));

	// Wishbone acknowledge and registered read data
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			rdData_q <= 32'h0;
		end else begin
			ack_q <= reqNew;
			if (reqNew) begin
				rdData_q <= {24'h0, rdSel};
			end
		end
	end

	assign statusVal = {afFlag_q, bfFlag_q, run_q, 1'b0, cnt.count};

	// Read mux; unmapped addresses read zero and are still acknowledged
	always_comb begin
		case (wb_adr_i)
			ADR_TRIG_CONFIG: rdSel = trigCfg_q;
			ADR_TRACE_STATUS: rdSel = statusVal;
			ADR_DEBUG_CONTROL: rdSel = {enable_q, run_q, 6'h0};
			default: rdSel = 8'h0;
		endcase
	end

	// Trigger configuration, locked during a run
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			trigCfg_q <= TRIG_CONFIG_RESET;
		end else if (wrTrig && !run_q) begin
			trigCfg_q <= wb_dat_i[7:0] & TRIG_CONFIG_WRITE_MASK;
		end
	end

	// Unit enable and run control
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			enable_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			if (wrCtrl) begin
				enable_q <= wb_dat_i[DEBUG_UNIT_ENABLE_BIT];
			end
			if (runStart) begin
				run_q <= 1'b1;
			end else if (runStop || runEnd) begin
				run_q <= 1'b0;
			end
		end
	end

	// Match flags; status has no write path
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			afFlag_q <= 1'b0;
			bfFlag_q <= 1'b0;
		end else if (runStart) begin
			afFlag_q <= 1'b0;
			bfFlag_q <= 1'b0;
		end else begin
			if (run_q && busAccess && hitA) begin
				afFlag_q <= 1'b1;
			end
			if (run_q && busAccess && hitB) begin
				bfFlag_q <= 1'b1;
			end
		end
	end

	// Sequencing memory for A-then modes and tag qualification
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			seenA_q <= 1'b0;
			tagPend_q <= 1'b0;
		end else if (runStart || !run_q) begin
			seenA_q <= 1'b0;
			tagPend_q <= 1'b0;
		end else begin
			if (busAccess && hitA) begin
				seenA_q <= 1'b1;
			end
			if (tagSel && rawTrig) begin
				tagPend_q <= 1'b1;
			end else if (opcodeExec) begin
				tagPend_q <= 1'b0;
			end
		end
	end

	// Capture sequencing
	always_comb begin
		stateNext = state_q;
		case (state_q)
			ST_IDLE: begin
				if (runStart) begin
					stateNext = beginMode ? ST_WAIT : ST_PRE;
				end
			end
			ST_PRE: begin
				if (runStop || runEnd) begin
					stateNext = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (runStop) begin
					stateNext = ST_IDLE;
				end else if (trig) begin
					stateNext = ST_POST;
				end
			end
			ST_POST: begin
				if (runStop || runEnd) begin
					stateNext = ST_IDLE;
				end
			end
			default: stateNext = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= stateNext;
		end
	end

	// Registered outputs toward buffer and break logic
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			trigger_q <= 1'b0;
			captureEn_q <= 1'b0;
			eventStore_q <= 1'b0;
			lowByte_q <= 1'b0;
			breakReq_q <= 1'b0;
		end else begin
			trigger_q <= trig;
			captureEn_q <= (stateNext == ST_PRE) || (stateNext == ST_POST);
			eventStore_q <= eventOnly && busAccess && hitB
				&& (state_q == ST_POST || (state_q == ST_WAIT && trig));
			lowByte_q <= eventOnly;
			breakReq_q <= runEnd && !runStop;
		end
	end

	// Valid word counter hookup
	assign cnt.clear = runStart;
	assign cnt.inc = run_q && wordStored;

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdData_q;
	assign trigger = trigger_q;
	assign captureEn = captureEn_q;
	assign eventStore = eventStore_q;
	assign lowByteOnly = lowByte_q;
	assign breakReq = breakReq_q;
	assign runActive = run_q;
	assign unitEnable = enable_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_cfg_write_lock: assert property (run_q && wrTrig |=> $stable(trigCfg_q))
		else $error("trigger config changed during run");
	a_cfg_fixed_bits: assert property (trigCfg_q[5:4] == 2'b00)
		else $error("trigger config bits 5:4 not zero");
	a_tag_needs_exec: assert property (tagSel && !(tagPend_q && opcodeExec) |=> !trigger)
		else $error("tag trigger without executed opcode");
	a_end_trace_fill: assert property (runStart && !beginMode
		|=> captureEn && state_q == ST_PRE)
		else $error("end trace not filling after start");
	a_event_is_begin: assert property (runStart && eventOnly
		|=> state_q == ST_WAIT && !captureEn)
		else $error("event-only run not begin type");
	a_a_only_fires: assert property (run_q && !tagSel && mode == MODE_A_ONLY
		&& busAccess && hitA |=> trigger)
		else $error("A-only match did not trigger");
	a_dead_modes: assert property (run_q && mode >= MODE_FIRST_DEAD && !tagSel |=> !trigger)
		else $error("trigger in a no-trigger mode");
	a_inside_range: assert property (run_q && !tagSel && mode == MODE_INSIDE_RANGE
		&& busAccess && addrGeA && addrLeB |=> trigger)
		else $error("inside range access did not trigger");
	a_flag_a_start: assert property (runStart |=> !afFlag_q ##1 (afFlag_q
		|| !($past(busAccess) && $past(hitA))))
		else $error("match A flag wrong after start");
	a_flag_b_hit: assert property (run_q && !runStart && busAccess && hitB |=> bfFlag_q)
		else $error("match B flag not set on B match");
	a_run_mirror: assert property (runStart
		|=> runActive && statusVal[RUN_ACTIVE_FLAG_BIT])
		else $error("run flag not set by start write");
	a_run_end_break: assert property (runEnd && !runStop
		|=> !runActive && breakReq ##1 !breakReq)
		else $error("natural run end not seen");
	a_manual_stop: assert property (runStop |=> !runActive && !captureEn && !breakReq)
		else $error("manual stop did not end run");
	a_count_start: assert property (runStart |=> cnt.count == 4'h0)
		else $error("valid count not cleared at run start");
	a_count_idle_hold: assert property (!run_q && !runStart |=> $stable(cnt.count))
		else $error("valid count moved while idle");
	a_status_ro: assert property (wrStat && !run_q |=> $stable(statusVal))
		else $error("status changed by a write");
	a_low_byte: assert property (run_q && eventOnly |-> ##1 lowByteOnly)
		else $error("event-only mode without low byte storage");
	a_reset_zero: assert property (disable iff (1'b0) !nrst
		|=> trigCfg_q == 8'h00 && statusVal == 8'h00)
		else $error("registers not zero after reset");

	c_begin_run: cover property (state_q == ST_POST && fifoFull && run_q);
	c_end_run: cover property (state_q == ST_PRE && trig);
	c_tag_trigger: cover property (tagSel && tagPend_q && opcodeExec && run_q);
	c_manual_stop: cover property (runStop);
endmodule

//--- sim/dts_fifo_model.sv
module dts_fifo_model
	import dts_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH,
	parameter bit SLOW = 1'b1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic captureEn,
	input wire logic eventStore,
	input wire logic runActive,
	output logic wordStored,
	output logic fifoFull
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic tick = 1'b0;
	// Store a word per request, every other cycle when slow
	always @(posedge sys_clk) begin
		tick <= ~tick;
		wordStored <= 1'b0;
		if (!nrst || !runActive) begin
			cnt <= 0;
		end else if ((captureEn || eventStore) && cnt < DEPTH && (tick || !SLOW)) begin
			cnt <= cnt + 1;
			wordStored <= 1'b1;
		end
	end
	// Own tally of words held
	assign fifoFull = (cnt == DEPTH);
endmodule

//--- sim/dts_trigger_status_tb_top.sv
module dts_trigger_status_tb_top
	import dts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sysClk, nrst, cyc, stb, we, bus, hA, hB, dB, geA, leB, opx, ws, full;
	logic trig, capEn, evSt, lowB, brk, run, uen, ack, t;
	logic [7:0] adr;
	logic [3:0] sel, m;
	logic [31:0] dw, dr, rd;
	logic [5:0] v;
	int nErrors, samplesChecked, cycCount, trigCnt, brkCnt, evCnt, k, b, e;

	dts_trigger_status dts_trigger_status_inst (.sys_clk(sysClk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .busAccess(bus), .hitA(hA), .hitB(hB), .dataHitB(dB),
		.addrGeA(geA), .addrLeB(leB), .opcodeExec(opx), .wordStored(ws), .fifoFull(full),
		.trigger(trig), .captureEn(capEn), .eventStore(evSt), .lowByteOnly(lowB),
		.breakReq(brk), .runActive(run), .unitEnable(uen));
	dts_fifo_model dts_fifo_model_inst (.sys_clk(sysClk), .nrst(nrst), .captureEn(capEn),
		.eventStore(evSt), .runActive(run), .wordStored(ws), .fifoFull(full));

	initial begin
		sysClk = 1'b0;
		forever #4 sysClk = ~sysClk;
	end

	// Event counters and hang guard
	always @(posedge sysClk) begin
		cycCount++;
		if (trig === 1'b1) trigCnt++;
		if (brk === 1'b1) brkCnt++;
		if (evSt === 1'b1) evCnt++;
		if (cycCount > 20000) begin
			nErrors++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("errors %0d checks %0d", nErrors, samplesChecked);
		if (nErrors == 0 && samplesChecked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sysClk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		dw <= {24'h0, d};
		do begin
			@(posedge sysClk);
		end while (ack !== 1'b1);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge sysClk);
		chk(ack, 1'b0);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask

	// Bit order: exec, access, A, B, data B, at least A, at most B
	task automatic pulse(input logic [6:0] x);
		@(posedge sysClk);
		{opx, bus, hA, hB, dB, geA, leB} <= x;
		@(posedge sysClk);
		{opx, bus, hA, hB, dB, geA, leB} <= 7'h00;
	endtask

	function automatic logic ev(input logic [3:0] md);
		return md == MODE_EVENT_B || md == MODE_A_THEN_EVENT_B;
	endfunction

	// Trigger expected from one qualified cycle with nothing seen before
	function automatic logic exp_trig(input logic [3:0] md, input logic [5:0] x);
		logic a, bb, d, g, l;
		{a, bb, d, g, l} = x[4:0];
		if (!x[5]) return 1'b0;
		case (md)
			MODE_A_ONLY: return a;
			MODE_A_OR_B: return a | bb;
			MODE_EVENT_B: return bb;
			MODE_A_AND_DATA_B: return a & d;
			MODE_A_AND_NOT_DATA_B: return a & ~d;
			MODE_INSIDE_RANGE: return g & l;
			MODE_OUTSIDE_RANGE: return ~g | ~l;
			default: return 1'b0;
		endcase
	endfunction

	initial begin
		{cyc, stb, we, bus, hA, hB, dB, geA, leB, opx} = '0;
		adr = 8'h00;
		sel = 4'hf;
		dw = 32'h0;
		nrst = 1'b0;
		{nErrors, samplesChecked, cycCount, trigCnt, brkCnt, evCnt} = '0;
		void'($urandom(32'h2299cc82));
		repeat (16) @(posedge sysClk);
		nrst <= 1'b1;
		rdchk(ADR_TRIG_CONFIG, 32'h0);
		rdchk(ADR_TRACE_STATUS, 32'h0);
		wb(1'b1, ADR_TRIG_CONFIG, 8'hff);
		rdchk(ADR_TRIG_CONFIG, 32'hcf);
		rdchk(8'h0c, 32'h0);
		// Every mode code with a random comparator cycle
		for (int i = 0; i < 48; i++) begin
			m = i[3:0];
			v = 6'($urandom);
			v[5] = ($urandom % 4) != 0;
			if (ev(m) || m == MODE_A_THEN_B) v[3] = v[3] & ~v[4];
			t = exp_trig(m, v);
			wb(1'b1, ADR_TRIG_CONFIG, {4'h0, m});
			wb(1'b1, ADR_DEBUG_CONTROL, 8'hc0);
			wb(1'b1, ADR_TRIG_CONFIG, {4'h8, ~m});
			rdchk(ADR_TRIG_CONFIG, {28'h0, m});
			chk(lowB, ev(m));
			chk(capEn, !ev(m));
			k = trigCnt;
			e = evCnt;
			pulse({1'b0, v});
			waitc(3);
			chk(32'(trigCnt - k), t);
			chk(32'(evCnt - e), t && ev(m));
			chk(run, !(t && !ev(m)));
			wb(1'b1, ADR_TRACE_STATUS, 8'hff);
			wb(1'b0, ADR_TRACE_STATUS, 8'h00);
			chk(rd[7:5], {v[5] & v[4], v[5] & v[3], !(t && !ev(m))});
			wb(1'b1, ADR_DEBUG_CONTROL, {i[0], 7'h0});
			chk(run, 1'b0);
			chk(uen, i[0]);
		end
		// A then B over two cycles
		wb(1'b1, ADR_TRIG_CONFIG, {4'h0, MODE_A_THEN_B});
		wb(1'b1, ADR_DEBUG_CONTROL, 8'hc0);
		k = trigCnt;
		pulse(7'h30);
		pulse(7'h28);
		waitc(3);
		chk(32'(trigCnt - k), 32'h1);
		wb(1'b1, ADR_DEBUG_CONTROL, 8'h00);
		// Tag qualification waits for execution
		wb(1'b1, ADR_TRIG_CONFIG, 8'h80);
		wb(1'b1, ADR_DEBUG_CONTROL, 8'hc0);
		k = trigCnt;
		b = brkCnt;
		pulse(7'h30);
		waitc(4);
		chk(32'(trigCnt - k), 32'h0);
		pulse(7'h40);
		waitc(3);
		chk(32'(trigCnt - k), 32'h1);
		chk(run, 1'b0);
		chk(32'(brkCnt - b), 32'h1);
		// Begin trace fills the buffer, then count holds
		wb(1'b1, ADR_TRIG_CONFIG, 8'h40);
		wb(1'b1, ADR_DEBUG_CONTROL, 8'hc0);
		chk(capEn, 1'b0);
		b = brkCnt;
		pulse(7'h30);
		for (int n = 0; n < 100 && brkCnt == b; n++) waitc(1);
		chk(32'(brkCnt - b), 32'h1);
		chk(run, 1'b0);
		rdchk(ADR_TRACE_STATUS, 32'h88);
		rdchk(ADR_TRACE_STATUS, 32'h88);
		wb(1'b1, ADR_DEBUG_CONTROL, 8'hc0);
		rdchk(ADR_TRACE_STATUS, 32'h20);
		wb(1'b1, ADR_DEBUG_CONTROL, 8'h00);
		end_sim();
	end
endmodule
